/* File: core/nv_consts.vh */
`ifndef NV_CONSTS_VH
`define NV_CONSTS_VH

// Register word indexes; the byte address on the bus is four times the index.
`define NV_CTRL_INDEX       16'h103B
`define NV_GUARD_INDEX      16'h1035
`define NV_OPTION_INDEX     16'h1039
`define NV_SETUP_INDEX      16'h103F

// Reset values.
`define NV_CTRL_RESET       8'h00
`define NV_GUARD_RESET      5'h1F
`define NV_OPTION_RESET     8'h00
`define NV_ERASED           8'hFF

// Fields of nv_program_control.
`define NV_BIT_VOLT         0
`define NV_BIT_LATCH        1
`define NV_BIT_ERASE        2
`define NV_BIT_ROW          3
`define NV_BIT_BYTE         4
`define NV_BIT_OTP          5
`define NV_BIT_EVEN         6
`define NV_BIT_ODD          7

// Fields of block_write_guard, the option register and the setup register.
`define NV_GUARD_SETUP_BIT  4
`define NV_PUMP_SEL_BIT     6
`define NV_NIBBLE_MSB       7
`define NV_NIBBLE_LSB       4

// Array geometry: base as high word-index bits of the CPU space, block starts as array offsets.
`define NV_SMALL_BASE_HI    7'h5B
`define NV_SMALL_BYTES      512
`define NV_LARGE_BYTES      2048
`define NV_BLK1_START       11'h020
`define NV_BLK2_START       11'h060
`define NV_BLK3_START       11'h0E0
`define NV_ROW_BYTES        16

// Timing.
`define NV_UNLOCK_CYCLES    7'h40
`define NV_CLK_HZ           50000000
`define NV_PROGRAM_TIME_US  10000
`define NV_PROGRAM_CYCLES   (`NV_PROGRAM_TIME_US * (`NV_CLK_HZ / 1000000))

// Bus encodings.
`define NV_HRESP_OKAY       1'b0

`endif

/* File: core/nv_hv_timer.v */
`timescale 1ns/10ps
module nv_hv_timer #(
  parameter CNT_W  = 24,
  parameter CYCLES = 500000
) (
  // Clock and control
  input  wire ref_clk,
  input  wire srst,
  input  wire ce,
  // Timer
  input  wire run,
  output reg  done
);
  // The count is cut to the counter width on purpose; CYCLES must fit in CNT_W bits.
  localparam [31:0]      LAST_W = CYCLES - 1;
  localparam [CNT_W-1:0] LAST   = LAST_W[CNT_W-1:0];

  reg [CNT_W-1:0] count_reg;
  reg             fired_reg;

  // One pulse per high-voltage phase; a phase that is left on longer does not repeat it.
  always @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= {CNT_W{1'b0}};
      fired_reg <= 1'b0;
      done      <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!run) begin
        count_reg <= {CNT_W{1'b0}};
        fired_reg <= 1'b0;
      end else if (!fired_reg) begin
        if (count_reg == LAST) begin
          done      <= 1'b1;
          fired_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end
endmodule // nv_hv_timer

/* File: core/eeprom_program_erase_control.v */
// What this block does
// - Guard register bits 7 to 5 read zero.
// - Protected setup register ignores program and erase.
// - Four guard bits block their array blocks.
// - Large array: quarters, base from setup nibble.
// - Byte erase overrides row erase.
// - Row erases sixteen bytes, else bulk erase.
// - Erase select chooses erase over program.
// - Latch clear reads; latch set latches writes.
// - Voltage bit connects high voltage to array.
// - OTP latch and array latch exclusive.
// - Program ignores byte and row bits.
// - Setup register programmable in every mode.
// - Security forces single-chip modes only.
// - Latch and voltage together set neither while latch is clear.
// - Voltage only after latch, write, then both.
// - Guard resets ones; clears only early window.
// - Test modes lift the guard write window.
`timescale 1ns/10ps
`include "nv_consts.vh"
module eeprom_program_erase_control #(
  parameter OTP_VARIANT    = 0,
  parameter LARGE_ARRAY    = 0,
  parameter PROGRAM_CYCLES = `NV_PROGRAM_CYCLES
) (
  // Clock, reset and enable
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Mode pins
  input  wire        test_mode_pin,
  input  wire        security_pin,
  // Status to the rest of the chip
  output reg         program_voltage_on,
  output reg         pump_clock_select,
  output reg         single_chip_only,
  output reg  [3:0]  setup_base_nibble
);
  localparam ARRAY_BYTES = LARGE_ARRAY ? `NV_LARGE_BYTES : `NV_SMALL_BYTES;

  reg [7:0]  cells [0:`NV_LARGE_BYTES-1];
  reg [7:0]  ctrl_reg;
  reg [7:0]  ctrl_next;
  reg [4:0]  guard_reg;
  reg        pump_sel_reg;
  reg [7:0]  setup_cell_reg;
  reg [3:0]  nibble_reg;
  reg        capture_pending_reg;
  reg        armed_reg;
  reg [15:0] lat_addr_reg;
  reg [7:0]  lat_data_reg;
  reg        lat_setup_reg;
  reg [6:0]  window_cnt_reg;
  reg        dp_valid_reg;
  reg        dp_write_reg;
  reg        dp_mapped_reg;
  reg [15:0] dp_addr_reg;
  reg        test_sync1_reg;
  reg        test_sync2_reg;
  reg        sec_sync1_reg;
  reg        sec_sync2_reg;
  reg [7:0]  rd_value;
  reg [10:0] row_base;
  integer    i;
  integer    j;

  wire       take_phase  = hsel && htrans[1] && hready;
  wire       addr_mapped = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
  wire [7:0] wbyte       = hwdata[7:0];
  wire       wr_now      = dp_valid_reg && dp_write_reg && dp_mapped_reg;
  wire       hv_done;
  wire [10:0] lat_idx    = array_index(lat_addr_reg);

  // Array window decode, shared by reads and writes.
  function in_array;
    input [15:0] a;
    input [3:0]  nib;
    begin
      if (LARGE_ARRAY != 0)
        in_array = (a[15:12] == nib) && a[11];
      else
        in_array = (a[15:9] == `NV_SMALL_BASE_HI);
    end
  endfunction

  function [10:0] array_index;
    input [15:0] a;
    begin
      if (LARGE_ARRAY != 0)
        array_index = a[10:0];
      else
        array_index = {2'b00, a[8:0]};
    end
  endfunction

  // Guard block that owns a byte of the array.
  function [1:0] block_of;
    input [10:0] idx;
    begin
      if (LARGE_ARRAY != 0)
        block_of = idx[10:9];
      else if (idx < `NV_BLK1_START)
        block_of = 2'd0;
      else if (idx < `NV_BLK2_START)
        block_of = 2'd1;
      else if (idx < `NV_BLK3_START)
        block_of = 2'd2;
      else
        block_of = 2'd3;
    end
  endfunction

  // Array and setup register reads while the latch is set return zero, since the array bus is owned by the latch.
  always @* begin
    rd_value = 8'h00;
    if (dp_addr_reg == `NV_CTRL_INDEX)
      rd_value = ctrl_reg;
    else if (dp_addr_reg == `NV_GUARD_INDEX)
      rd_value = {3'b000, guard_reg};
    else if (dp_addr_reg == `NV_OPTION_INDEX)
      rd_value = {1'b0, pump_sel_reg, 6'b000000};
    else if (dp_addr_reg == `NV_SETUP_INDEX)
      rd_value = ctrl_reg[`NV_BIT_LATCH] ? 8'h00 : setup_cell_reg;
    else if (in_array(dp_addr_reg, nibble_reg))
      rd_value = ctrl_reg[`NV_BIT_LATCH] ? 8'h00 : cells[array_index(dp_addr_reg)];
  end

  // Sequence checks on a write to the program control register.
  always @* begin
    ctrl_next = wbyte;
    if (wbyte[`NV_BIT_LATCH] && wbyte[`NV_BIT_VOLT] && !ctrl_reg[`NV_BIT_LATCH]) begin
      ctrl_next[`NV_BIT_LATCH] = 1'b0;
      ctrl_next[`NV_BIT_VOLT]  = 1'b0;
    end else if (wbyte[`NV_BIT_VOLT] && !(ctrl_reg[`NV_BIT_LATCH] && armed_reg)) begin
      ctrl_next[`NV_BIT_VOLT] = 1'b0;
    end
    if (OTP_VARIANT == 0)
      ctrl_next[`NV_BIT_OTP] = 1'b0;
    else if (ctrl_next[`NV_BIT_LATCH])
      ctrl_next[`NV_BIT_OTP] = 1'b0;
  end

  always @* begin
    row_base = {lat_idx[10:4], 4'h0};
  end

  nv_hv_timer #(
    .CNT_W  (24),
    .CYCLES (PROGRAM_CYCLES)
  ) hv_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .run     (ctrl_reg[`NV_BIT_VOLT]),
    .done    (hv_done)
  );

  // Cells are nonvolatile: they start erased and survive reset.
  initial begin
    for (j = 0; j < `NV_LARGE_BYTES; j = j + 1)
      cells[j] = `NV_ERASED;
    setup_cell_reg = `NV_ERASED;
  end

  // Cell updates at the end of the high-voltage time.
  always @(posedge ref_clk) begin
    if (ce && hv_done) begin
      if (lat_setup_reg) begin
        if (!guard_reg[`NV_GUARD_SETUP_BIT]) begin
          if (ctrl_reg[`NV_BIT_ERASE])
            setup_cell_reg <= `NV_ERASED;
          else
            setup_cell_reg <= setup_cell_reg & lat_data_reg;
        end
      end else if (!ctrl_reg[`NV_BIT_ERASE]) begin
        if (!guard_reg[block_of(lat_idx)])
          cells[lat_idx] <= cells[lat_idx] & lat_data_reg;
      end else if (ctrl_reg[`NV_BIT_BYTE]) begin
        if (!guard_reg[block_of(lat_idx)])
          cells[lat_idx] <= `NV_ERASED;
      end else if (ctrl_reg[`NV_BIT_ROW]) begin
        for (i = 0; i < `NV_ROW_BYTES; i = i + 1)
          if (!guard_reg[block_of(row_base + i[10:0])])
            cells[row_base + i[10:0]] <= `NV_ERASED;
      end else begin
        for (i = 0; i < ARRAY_BYTES; i = i + 1)
          if (!guard_reg[block_of(i[10:0])])
            cells[i] <= `NV_ERASED;
      end
    end
  end

  // Bus slave, control registers and mode pins.
  always @(posedge ref_clk) begin
    if (srst) begin
      hrdata              <= 32'h00000000;
      hreadyout           <= 1'b1;
      hresp               <= `NV_HRESP_OKAY;
      dp_valid_reg        <= 1'b0;
      dp_write_reg        <= 1'b0;
      dp_mapped_reg       <= 1'b0;
      dp_addr_reg         <= 16'h0000;
      ctrl_reg            <= `NV_CTRL_RESET;
      guard_reg           <= `NV_GUARD_RESET;
      pump_sel_reg        <= 1'b0;
      armed_reg           <= 1'b0;
      lat_addr_reg        <= 16'h0000;
      lat_data_reg        <= 8'h00;
      lat_setup_reg       <= 1'b0;
      window_cnt_reg      <= 7'h00;
      capture_pending_reg <= 1'b1;
      nibble_reg          <= 4'h0;
      test_sync1_reg      <= 1'b0;
      test_sync2_reg      <= 1'b0;
      sec_sync1_reg       <= 1'b0;
      sec_sync2_reg       <= 1'b0;
      program_voltage_on  <= 1'b0;
      pump_clock_select   <= 1'b0;
      single_chip_only    <= 1'b0;
      setup_base_nibble   <= 4'h0;
    end else if (ce) begin
      test_sync1_reg <= test_mode_pin;
      test_sync2_reg <= test_sync1_reg;
      sec_sync1_reg  <= security_pin;
      sec_sync2_reg  <= sec_sync1_reg;
      single_chip_only <= sec_sync2_reg;
      if (window_cnt_reg != `NV_UNLOCK_CYCLES)
        window_cnt_reg <= window_cnt_reg + 1'b1;
      // The base nibble is only taken after a reset so a half-done change cannot move the array.
      if (capture_pending_reg) begin
        nibble_reg          <= setup_cell_reg[`NV_NIBBLE_MSB:`NV_NIBBLE_LSB];
        setup_base_nibble   <= setup_cell_reg[`NV_NIBBLE_MSB:`NV_NIBBLE_LSB];
        capture_pending_reg <= 1'b0;
      end
      // Reads take one wait state so a write just ahead of them is always visible.
      if (dp_valid_reg && !dp_write_reg) begin
        hrdata       <= {24'h000000, rd_value};
        hreadyout    <= 1'b1;
        dp_valid_reg <= 1'b0;
      end else begin
        dp_valid_reg <= take_phase;
        if (take_phase) begin
          dp_write_reg  <= hwrite;
          dp_mapped_reg <= addr_mapped;
          dp_addr_reg   <= haddr[17:2];
          hreadyout     <= hwrite;
        end
      end
      if (wr_now) begin
        if (dp_addr_reg == `NV_CTRL_INDEX) begin
          ctrl_reg           <= ctrl_next;
          program_voltage_on <= ctrl_next[`NV_BIT_VOLT];
          if (!ctrl_next[`NV_BIT_LATCH])
            armed_reg <= 1'b0;
        end else if (dp_addr_reg == `NV_GUARD_INDEX) begin
          if (test_sync2_reg || (window_cnt_reg != `NV_UNLOCK_CYCLES))
            guard_reg <= wbyte[4:0];
          else
            guard_reg <= guard_reg | wbyte[4:0];
        end else if (dp_addr_reg == `NV_OPTION_INDEX) begin
          pump_sel_reg      <= wbyte[`NV_PUMP_SEL_BIT];
          pump_clock_select <= wbyte[`NV_PUMP_SEL_BIT];
        end else if (ctrl_reg[`NV_BIT_LATCH] && !ctrl_reg[`NV_BIT_VOLT]) begin
          if (dp_addr_reg == `NV_SETUP_INDEX) begin
            if (!guard_reg[`NV_GUARD_SETUP_BIT]) begin
              lat_addr_reg  <= dp_addr_reg;
              lat_data_reg  <= wbyte;
              lat_setup_reg <= 1'b1;
              armed_reg     <= 1'b1;
            end
          end else if (in_array(dp_addr_reg, nibble_reg)) begin
            if (!guard_reg[block_of(array_index(dp_addr_reg))]) begin
              lat_addr_reg  <= dp_addr_reg;
              lat_data_reg  <= wbyte;
              lat_setup_reg <= 1'b0;
              armed_reg     <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule // eeprom_program_erase_control

/* File: testbench/eeprom_program_erase_control_checker.sv */
`timescale 1ns/10ps
`include "nv_consts.vh"
module eeprom_program_erase_control_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        srst,
  input wire        ce,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Pins and status
  input wire        security_pin,
  input wire        program_voltage_on,
  input wire        pump_clock_select,
  input wire        single_chip_only
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire        take   = hsel & htrans[1] & hready & ce;
  wire        hit    = haddr[31:11] == 21'h5B || haddr == 32'h000040FC;
  reg         wr_q;
  reg  [31:0] a_q;
  reg         lat_q;
  reg         arm_q;
  wire        ctl_wr = wr_q && a_q == 32'h000040EC;
  wire        hit_q  = a_q[31:11] == 21'h5B || a_q == 32'h000040FC;
  // The shadow latch copies the refusal of latch and voltage in one write.
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_q  <= 1'b0;
      a_q   <= 32'h00000000;
      lat_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      wr_q <= take & hwrite;
      a_q  <= haddr;
      if (ctl_wr) lat_q <= hwdata[1] & ~(hwdata[0] & ~lat_q);
      if (ctl_wr && !hwdata[1]) arm_q <= 1'b0;
      else if (wr_q && hit_q) arm_q <= 1'b1;
    end
  end
  sequence rd_take;
    take && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (rd_take |=> rd_answer)
    else $error("read wait state wrong");
  chk_guard_top: assert property ((rd_take ##0 haddr == 32'h000040D4) |=> rd_answer ##0 hrdata[7:5] == 3'h0)
    else $error("guard top bits not zero");
  chk_latched_read: assert property ((rd_take ##0 hit && lat_q) |=> ##1 hrdata == 32'h00000000)
    else $error("array read while latched");
  chk_both_refused: assert property (ctl_wr && hwdata[1:0] == 2'b11 && !lat_q |=> !program_voltage_on)
    else $error("latch and voltage set together");
  chk_volt_off: assert property (ctl_wr && !hwdata[0] |=> !program_voltage_on)
    else $error("voltage stays on");
  chk_volt_cause: assert property ($rose(program_voltage_on) |-> $past(ctl_wr && hwdata[0] && lat_q && arm_q))
    else $error("voltage without sequence");
  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_pump_sel: assert property (wr_q && a_q == 32'h000040E4 |=> pump_clock_select == $past(hwdata[6]))
    else $error("pump select wrong");
  chk_secure_mode: assert property ((security_pin && ce) [*4] |=> single_chip_only)
    else $error("security not applied");
endmodule // eeprom_program_erase_control_checker

bind eeprom_program_erase_control eeprom_program_erase_control_checker chk_inst (.ref_clk(ref_clk), .srst(srst),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .security_pin(security_pin),
  .program_voltage_on(program_voltage_on), .pump_clock_select(pump_clock_select), .single_chip_only(single_chip_only));

/* File: testbench/eeprom_program_erase_control_tb_top.sv */
`timescale 1ns/10ps
`include "nv_consts.vh"
module eeprom_program_erase_control_tb_top;
  localparam int          PC    = 20;
  localparam logic [31:0] CTRL  = {14'h0, `NV_CTRL_INDEX, 2'b00};
  localparam logic [31:0] GUARD = {14'h0, `NV_GUARD_INDEX, 2'b00};
  localparam logic [31:0] OPT   = {14'h0, `NV_OPTION_INDEX, 2'b00};
  localparam logic [31:0] SETUP = {14'h0, `NV_SETUP_INDEX, 2'b00};
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        test_pin = 1'b0;
  logic        sec_pin = 1'b0;
  logic        ce      = 1'b1;
  wire  [3:0]  nib;
  wire  [31:0] hrdata;
  wire         hready;
  wire         volt;
  wire         pump;
  wire         single;
  int          fails   = 0;
  int          checked = 0;
  int          cycles  = 0;
  int          ks[6]   = '{0, 1, 2, 16, 256, 0};
  logic [31:0] r;
  logic [7:0]  d;
  logic [7:0]  mem [int];
  always #10 ref_clk = ~ref_clk;
  eeprom_program_erase_control #(.PROGRAM_CYCLES(PC)) eeprom_program_erase_control_inst (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .test_mode_pin(test_pin), .security_pin(sec_pin),
    .program_voltage_on(volt), .pump_clock_select(pump), .single_chip_only(single), .setup_base_nibble(nib));
  task automatic end_of_test();
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One whole-word transfer; read data lands in r at the closing edge.
  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] v);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask
  function automatic logic [31:0] ad(input int k);
    return (k < 0) ? SETUP : 32'h0002D800 + 32'(k * 4);
  endfunction
  function automatic logic [7:0] cur(input int k);
    return mem.exists(k) ? mem[k] : 8'hFF;
  endfunction
  task automatic see(input int k);
    bus(ad(k), 1'b0, 8'h00);
    chk(r, {24'h0, cur(k)});
  endtask
  // Latch, target write, voltage, wait out the pulse, then back to read mode.
  task automatic op(input logic [7:0] m, input int k, input logic [7:0] v);
    bus(CTRL, 1'b1, m);
    bus(ad(k), 1'b1, v);
    bus(ad(k), 1'b0, 8'h00);
    chk(r, 32'h0);
    bus(CTRL, 1'b1, m | 8'h01);
    repeat (PC + 4) @(posedge ref_clk);
    bus(CTRL, 1'b1, 8'h00);
  endtask
  initial begin
    void'($urandom(95));
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(GUARD, 1'b0, 8'h00);
    chk(r, 32'h1F);
    bus(GUARD, 1'b1, 8'h00);
    bus(GUARD, 1'b0, 8'h00);
    chk(r, 32'h0);
    bus(GUARD, 1'b1, 8'hE1);
    bus(GUARD, 1'b0, 8'h00);
    chk(r, 32'h01);
    repeat (64) @(posedge ref_clk);
    bus(GUARD, 1'b1, 8'h00);
    bus(GUARD, 1'b0, 8'h00);
    chk(r, 32'h01);
    test_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus(GUARD, 1'b1, 8'h00);
    bus(GUARD, 1'b0, 8'h00);
    chk(r, 32'h0);
    test_pin <= 1'b0;
    bus(CTRL, 1'b1, 8'h03);
    bus(CTRL, 1'b0, 8'h00);
    chk(r, 32'h0);
    bus(CTRL, 1'b1, 8'h20);
    bus(CTRL, 1'b0, 8'h00);
    chk(r, 32'h0);
    bus(CTRL, 1'b1, 8'h02);
    bus(CTRL, 1'b1, 8'h03);
    @(posedge ref_clk);
    chk(volt, 1'b0);
    bus(CTRL, 1'b1, 8'h00);
    ks[5] = 32 + $urandom_range(0, 63);
    for (int i = -1; i < 6; i++) begin
      d = $urandom;
      op(8'h02, i < 0 ? -1 : ks[i], d);
      mem[i < 0 ? -1 : ks[i]] = cur(i < 0 ? -1 : ks[i]) & d;
      see(i < 0 ? -1 : ks[i]);
    end
    op(8'h1E, 0, $urandom);
    mem[0] = 8'hFF;
    see(0);
    see(1);
    op(8'h0E, 1, $urandom);
    mem[1] = 8'hFF;
    mem[2] = 8'hFF;
    see(2);
    see(16);
    d = $urandom;
    op(8'h1A, 16, d);
    mem[16] = cur(16) & d;
    see(16);
    bus(GUARD, 1'b1, 8'h08);
    op(8'h02, 256, 8'h00);
    see(256);
    op(8'h06, 40, $urandom);
    foreach (mem[k]) if (k >= 0 && k < 224) mem[k] = 8'hFF;
    see(16);
    see(256);
    see(-1);
    bus(GUARD, 1'b1, 8'h18);
    op(8'h16, -1, 8'h00);
    see(-1);
    bus(OPT, 1'b1, 8'h40);
    @(posedge ref_clk);
    chk(pump, 1'b1);
    // The bus is idle here, so freezing the clock enable cannot strand a transfer.
    ce      <= 1'b0;
    sec_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(single, 1'b0);
    ce <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(single, 1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(nib, cur(-1) >> 4);
    bus(GUARD, 1'b0, 8'h00);
    chk(r, 32'h1F);
    end_of_test();
  end
endmodule // eeprom_program_erase_control_tb_top
